// ===== dci_island_exchange.sv
`timescale 1ns/1ps
// Function
// - queue write side in producing island, read side in consuming island
// - shared memory has one port per island, each reads and writes
// - islands never touch the same address concurrently, via full flags
// - read data of a location being written is undefined
// - holding register read back by writer and read by other island
// - holding register is flip-flops of configurable width
// - holding register crosses with synchronisers and toggle handshake
// - each island writes samples only into its own half
// - after filling its half an island reads the other half
// - one clock input per island, used only by that island
// - each island has 8-bit sample input and output, clock and enable
module dci_island_exchange #(
    parameter int SAMPLE_W = dci_pkg::SAMPLE_W,
    parameter int HALF     = dci_pkg::HALF_DEPTH,
    parameter int QDEPTH   = dci_pkg::QUEUE_DEPTH,
    parameter int HOLD_W   = dci_pkg::HOLD_W
)(
    input  wire logic                           island_a_clock_in,
    input  wire logic                           island_b_clock_in,
    input  wire logic                           rst_n,
    input  wire logic                           island_a_clock_enable_in,
    input  wire logic                           island_b_clock_enable_in,
    input  wire logic [dci_pkg::SAMPLE_W-1:0]   a_sample_in,
    input  wire logic [dci_pkg::SAMPLE_W-1:0]   b_sample_in,
    output logic      [dci_pkg::SAMPLE_W-1:0]   a_sample_out,
    output logic      [dci_pkg::SAMPLE_W-1:0]   b_sample_out,
    output logic      [dci_pkg::SAMPLE_W-1:0]   b_queue_out,
    output logic                                b_queue_valid,
    output logic      [dci_pkg::HOLD_W-1:0]     a_hold_out,
    output logic      [dci_pkg::HOLD_W-1:0]     b_hold_readback
);
    import dci_pkg::*;

    localparam int IW = $clog2(HALF);
    localparam logic [IW-1:0] LAST = IW'(HALF - 1);

    // ======================================================
    // shared memory, one bank per island half
    logic [SAMPLE_W-1:0] bank_a [HALF];
    logic [SAMPLE_W-1:0] bank_b [HALF];

    logic [SYNC_STAGES-1:0] a_rst_sync_r;
    logic [SYNC_STAGES-1:0] b_rst_sync_r;
    wire                    a_rst_n = a_rst_sync_r[SYNC_STAGES-1];
    wire                    b_rst_n = b_rst_sync_r[SYNC_STAGES-1];

    dci_state_t             a_state_r;
    dci_state_t             a_state_nxt;
    dci_state_t             b_state_r;
    dci_state_t             b_state_nxt;
    logic [IW-1:0]          a_wr_idx_r;
    logic [IW-1:0]          a_rd_idx_r;
    logic [IW-1:0]          b_wr_idx_r;
    logic [IW-1:0]          b_rd_idx_r;
    logic                   a_full_r;
    logic                   b_full_r;
    logic                   a_bfull_s1_r;
    logic                   a_bfull_s2_r;
    logic                   b_afull_s1_r;
    logic                   b_afull_s2_r;
    logic                   b_req_r;
    logic                   b_ack_s1_r;
    logic                   b_ack_s2_r;
    logic                   a_req_s1_r;
    logic                   a_req_s2_r;
    logic                   a_ack_r;

    dci_stream_if #(.W(SAMPLE_W)) a_push ();
    dci_stream_if #(.W(SAMPLE_W)) b_pop ();

    // ======================================================
    // decode
    wire a_fill = a_state_r == ST_FILL;
    wire b_fill = b_state_r == ST_FILL;
    wire a_take = island_a_clock_enable_in && a_fill && a_push.ready;
    wire b_take = island_b_clock_enable_in && b_fill;
    wire a_last = a_wr_idx_r == LAST;
    wire b_last = b_wr_idx_r == LAST;
    wire a_read = island_a_clock_enable_in && a_state_r == ST_READ;
    wire b_read = island_b_clock_enable_in && b_state_r == ST_READ;
    wire b_pop_go   = b_pop.valid && b_pop.ready;
    wire b_hold_idle = b_req_r == b_ack_s2_r;
    wire b_hold_load = island_b_clock_enable_in && b_hold_idle;
    wire a_hold_new  = a_req_s2_r != a_ack_r;

    assign a_push.valid = island_a_clock_enable_in && a_fill;
    assign a_push.data  = a_sample_in;
    assign b_pop.ready  = island_b_clock_enable_in;

    dci_async_queue #(.W(SAMPLE_W), .DEPTH(QDEPTH)) u_queue (
        .wr_clk   (island_a_clock_in),
        .wr_rst_n (a_rst_n),
        .rd_clk   (island_b_clock_in),
        .rd_rst_n (b_rst_n),
        .wr       (a_push),
        .rd       (b_pop)
    );

    // ======================================================
    // state machines
    always_comb
    begin
        a_state_nxt = a_state_r;
        case (a_state_r)
            ST_FILL: if (a_take && a_last) a_state_nxt = ST_WAIT;
            ST_WAIT: if (a_bfull_s2_r) a_state_nxt = ST_READ;
            ST_READ: a_state_nxt = ST_READ;
            default: a_state_nxt = ST_FILL;
        endcase
    end

    always_comb
    begin
        b_state_nxt = b_state_r;
        case (b_state_r)
            ST_FILL: if (b_take && b_last) b_state_nxt = ST_WAIT;
            ST_WAIT: if (b_afull_s2_r) b_state_nxt = ST_READ;
            ST_READ: b_state_nxt = ST_READ;
            default: b_state_nxt = ST_FILL;
        endcase
    end

    // ======================================================
    // island A, own clock only
    always_ff @(posedge island_a_clock_in)
        a_rst_sync_r <= {a_rst_sync_r[SYNC_STAGES-2:0], rst_n};

    always_ff @(posedge island_a_clock_in)
    begin
        if (a_take)
            bank_a[a_wr_idx_r] <= a_sample_in;
    end

    always_ff @(posedge island_a_clock_in)
    begin
        if (!a_rst_n)
        begin
            a_state_r    <= ST_FILL;
            a_wr_idx_r   <= '0;
            a_rd_idx_r   <= '0;
            a_full_r     <= 1'b0;
            a_bfull_s1_r <= 1'b0;
            a_bfull_s2_r <= 1'b0;
            a_sample_out <= '0;
            a_req_s1_r   <= 1'b0;
            a_req_s2_r   <= 1'b0;
            a_ack_r      <= 1'b0;
            a_hold_out   <= '0;
        end
        else
        begin
            a_state_r    <= a_state_nxt;
            a_bfull_s1_r <= b_full_r;
            a_bfull_s2_r <= a_bfull_s1_r;
            a_req_s1_r   <= b_req_r;
            a_req_s2_r   <= a_req_s1_r;
            if (a_take)
                a_wr_idx_r <= a_wr_idx_r + 1'b1;
            if (a_take && a_last)
                a_full_r <= 1'b1;
            if (a_read)
            begin
                a_sample_out <= bank_b[a_rd_idx_r];
                a_rd_idx_r   <= a_rd_idx_r + 1'b1;
            end
            if (a_hold_new)
            begin
                a_hold_out <= b_hold_readback;
                a_ack_r    <= a_req_s2_r;
            end
        end
    end

    // ======================================================
    // island B, own clock only
    always_ff @(posedge island_b_clock_in)
        b_rst_sync_r <= {b_rst_sync_r[SYNC_STAGES-2:0], rst_n};

    always_ff @(posedge island_b_clock_in)
    begin
        if (b_take)
            bank_b[b_wr_idx_r] <= b_sample_in;
    end

    always_ff @(posedge island_b_clock_in)
    begin
        if (!b_rst_n)
        begin
            b_state_r       <= ST_FILL;
            b_wr_idx_r      <= '0;
            b_rd_idx_r      <= '0;
            b_full_r        <= 1'b0;
            b_afull_s1_r    <= 1'b0;
            b_afull_s2_r    <= 1'b0;
            b_sample_out    <= '0;
            b_queue_out     <= '0;
            b_queue_valid   <= 1'b0;
            b_req_r         <= 1'b0;
            b_ack_s1_r      <= 1'b0;
            b_ack_s2_r      <= 1'b0;
            b_hold_readback <= '0;
        end
        else
        begin
            b_state_r     <= b_state_nxt;
            b_afull_s1_r  <= a_full_r;
            b_afull_s2_r  <= b_afull_s1_r;
            b_ack_s1_r    <= a_ack_r;
            b_ack_s2_r    <= b_ack_s1_r;
            b_queue_valid <= b_pop_go;
            if (b_pop_go)
                b_queue_out <= b_pop.data;
            if (b_take)
                b_wr_idx_r <= b_wr_idx_r + 1'b1;
            if (b_take && b_last)
                b_full_r <= 1'b1;
            if (b_read)
            begin
                b_sample_out <= bank_a[b_rd_idx_r];
                b_rd_idx_r   <= b_rd_idx_r + 1'b1;
            end
            if (b_hold_load)
            begin
                b_hold_readback <= b_sample_in[HOLD_W-1:0];
                b_req_r         <= ~b_req_r;
            end
        end
    end

    // ======================================================
    // checks
    sequence s_a_last_take;
        a_take && a_last;
    endsequence

    sequence s_b_wait_release;
        b_state_r == ST_WAIT ##1 b_state_r == ST_READ;
    endsequence

    a_fill_to_wait : assert property (@(posedge island_a_clock_in)
        disable iff (!a_rst_n)
        s_a_last_take |=> a_state_r == ST_WAIT && a_full_r)
        else $error("island A did not stop after filling its half");

    a_read_after_full : assert property (@(posedge island_a_clock_in)
        disable iff (!a_rst_n)
        a_state_r == ST_READ |-> a_full_r && a_bfull_s2_r)
        else $error("island A reads before both halves are full");

    a_b_sync_gate : assert property (@(posedge island_b_clock_in)
        disable iff (!b_rst_n)
        s_b_wait_release |-> $past(b_afull_s2_r))
        else $error("island B read without synchronised full flag");

    a_bank_own_write : assert property (@(posedge island_a_clock_in)
        disable iff (!a_rst_n)
        a_take |=> bank_a[$past(a_wr_idx_r)] == $past(a_sample_in))
        else $error("island A sample not stored in its half");

    a_queue_stall : assert property (@(posedge island_a_clock_in)
        disable iff (!a_rst_n)
        a_fill && !a_push.ready |=> $stable(a_wr_idx_r))
        else $error("island A advanced while queue was full");

    a_read_data : assert property (@(posedge island_b_clock_in)
        disable iff (!b_rst_n)
        b_read |=> b_sample_out == bank_a[$past(b_rd_idx_r)])
        else $error("island B output does not match the A half");

    a_hold_stable : assert property (@(posedge island_b_clock_in)
        disable iff (!b_rst_n)
        !b_hold_idle |=> $stable(b_hold_readback))
        else $error("holding register changed during handshake");

    a_hold_readback : assert property (@(posedge island_b_clock_in)
        disable iff (!b_rst_n)
        b_hold_load |=> b_hold_readback == $past(b_sample_in)
                        ##[1:12] !b_hold_idle)
        else $error("holding register readback or request wrong");

    a_hold_capture : assert property (@(posedge island_a_clock_in)
        disable iff (!a_rst_n)
        a_hold_new |=> a_hold_out == $past(b_hold_readback) && !a_hold_new)
        else $error("island A did not capture the holding register");
endmodule : dci_island_exchange

// ===== dci_pkg.sv
// ==========================================================
// shared constants
package dci_pkg;
    localparam int SAMPLE_W     = 8;
    localparam int HALF_DEPTH   = 16;
    localparam int QUEUE_DEPTH  = 8;
    localparam int HOLD_W       = 8;
    localparam int A_PERIOD_NS  = 10;
    localparam int B_PERIOD_NS  = 15;
    localparam int SYNC_STAGES  = 2;

    typedef enum logic [2:0]
    {
        ST_FILL = 3'h1,
        ST_WAIT = 3'h2,
        ST_READ = 3'h4
    } dci_state_t;
endpackage : dci_pkg

// ===== dci_stream_if.sv
`timescale 1ns/1ps
// ==========================================================
// valid/ready word stream between the top and the queue
interface dci_stream_if #(
    parameter int W = dci_pkg::SAMPLE_W
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : dci_stream_if

// ===== dci_async_queue.sv
`timescale 1ns/1ps
// ==========================================================
// dual-clock queue, gray-coded pointers
module dci_async_queue #(
    parameter int W     = dci_pkg::SAMPLE_W,
    parameter int DEPTH = dci_pkg::QUEUE_DEPTH
)(
    input wire logic     wr_clk,
    input wire logic     wr_rst_n,
    input wire logic     rd_clk,
    input wire logic     rd_rst_n,
    dci_stream_if.snk    wr,
    dci_stream_if.src    rd
);
    import dci_pkg::*;

    localparam int AW = $clog2(DEPTH);

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : to_gray

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wbin_r;
    logic [AW:0]  wgray_r;
    logic [AW:0]  rbin_r;
    logic [AW:0]  rgray_r;
    logic [AW:0]  rgray_s1_r;
    logic [AW:0]  rgray_s2_r;
    logic [AW:0]  wgray_s1_r;
    logic [AW:0]  wgray_s2_r;

    wire          full    = wgray_r == {~rgray_s2_r[AW:AW-1],
                                        rgray_s2_r[AW-2:0]};
    wire          empty   = rgray_r == wgray_s2_r;
    wire          wr_go   = wr.valid && !full;
    wire          rd_go   = rd.ready && !empty;
    wire [AW:0]   wbin_nxt = wbin_r + {{AW{1'b0}}, 1'b1};
    wire [AW:0]   rbin_nxt = rbin_r + {{AW{1'b0}}, 1'b1};

    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data  = mem[rbin_r[AW-1:0]];

    // ======================================================
    // write side, producing domain
    always_ff @(posedge wr_clk)
    begin
        if (wr_go)
            mem[wbin_r[AW-1:0]] <= wr.data;
    end

    always_ff @(posedge wr_clk)
    begin
        if (!wr_rst_n)
        begin
            wbin_r     <= '0;
            wgray_r    <= '0;
            rgray_s1_r <= '0;
            rgray_s2_r <= '0;
        end
        else
        begin
            rgray_s1_r <= rgray_r;
            rgray_s2_r <= rgray_s1_r;
            if (wr_go)
            begin
                wbin_r  <= wbin_nxt;
                wgray_r <= to_gray(wbin_nxt);
            end
        end
    end

    // ======================================================
    // read side, consuming domain
    always_ff @(posedge rd_clk)
    begin
        if (!rd_rst_n)
        begin
            rbin_r     <= '0;
            rgray_r    <= '0;
            wgray_s1_r <= '0;
            wgray_s2_r <= '0;
        end
        else
        begin
            wgray_s1_r <= wgray_r;
            wgray_s2_r <= wgray_s1_r;
            if (rd_go)
            begin
                rbin_r  <= rbin_nxt;
                rgray_r <= to_gray(rbin_nxt);
            end
        end
    end

    a_queue_no_over : assert property (@(posedge wr_clk)
        disable iff (!wr_rst_n) full |=> $stable(wbin_r))
        else $error("queue accepts a word while full");
endmodule : dci_async_queue

// ===== dci_far_island.sv
`timescale 1ns/1ps
// ==========================================================
// far island: sample source with adjustable spacing
module dci_far_island (
    input  wire logic                          clk,
    input  wire logic                          run,
    input  wire logic [3:0]                    gap,
    output logic                               sample_en,
    output logic      [dci_pkg::SAMPLE_W-1:0]  sample
);
    import dci_pkg::*;

    logic [3:0] idx_r;
    logic [3:0] wait_r;

    initial
    begin
        sample_en = 1'b0;
        sample    = '0;
        idx_r     = 4'h0;
        wait_r    = 4'h0;
    end

    // ==========================================================
    // one sample per enabled edge, own clock only
    always @(posedge clk)
    begin
        if (run && wait_r == 4'h0)
        begin
            sample_en <= 1'b1;
            sample    <= 8'h50 + {4'h0, idx_r};
            idx_r     <= idx_r + 4'h1;
            wait_r    <= gap;
        end
        else
        begin
            sample_en <= 1'b0;
            // idle edges invert the word, so every second idle edge shows the stale word again
            sample    <= ~sample;
            if (wait_r != 4'h0)
                wait_r <= wait_r - 4'h1;
        end
    end
endmodule : dci_far_island

// ===== dci_island_exchange_tb.sv
`timescale 1ns/1ps
// ==========================================================
// two-island bench
module dci_island_exchange_tb;
    import dci_pkg::*;

    typedef struct packed
    {
        logic [7:0] a_in;
        logic [7:0] b_in;
    } dci_row_t;

    logic        island_a_clock_in = 1'b0;
    logic        island_b_clock_in = 1'b0;
    logic        rst_n             = 1'b0;
    logic        a_en              = 1'b0;
    logic [7:0]  a_in              = 8'h00;
    logic        far_run           = 1'b0;
    logic [3:0]  far_gap           = 4'h0;
    logic        mon_on            = 1'b0;
    logic        b_en;
    logic [7:0]  b_in;
    logic [7:0]  a_out;
    logic [7:0]  b_out;
    logic [7:0]  q_out;
    logic        q_valid;
    logic [7:0]  a_hold;
    logic [7:0]  b_hold;
    logic [7:0]  a_prev            = 8'h00;
    logic [7:0]  b_prev            = 8'h00;
    logic [7:0]  ah_prev           = 8'h00;
    logic [7:0]  bh_prev           = 8'h00;
    logic [7:0]  bi_prev           = 8'h00;
    int          a_n               = 0;
    int          b_n               = 0;
    int          q_k               = 0;
    int          q_x               = 0;
    int          bad_count         = 0;
    int          checked           = 0;
    dci_row_t    rows [16];

    // ==========================================================
    // clocks, unrelated periods
    always #5.0 island_a_clock_in = ~island_a_clock_in;
    always #7.5 island_b_clock_in = ~island_b_clock_in;

    dci_island_exchange dci_island_exchange_inst (
        .island_a_clock_in        (island_a_clock_in),
        .island_b_clock_in        (island_b_clock_in),
        .rst_n                    (rst_n),
        .island_a_clock_enable_in (a_en),
        .island_b_clock_enable_in (b_en),
        .a_sample_in              (a_in),
        .b_sample_in              (b_in),
        .a_sample_out             (a_out),
        .b_sample_out             (b_out),
        .b_queue_out              (q_out),
        .b_queue_valid            (q_valid),
        .a_hold_out               (a_hold),
        .b_hold_readback          (b_hold)
    );

    dci_far_island dci_far_island_inst (
        .clk       (island_b_clock_in),
        .run       (far_run),
        .gap       (far_gap),
        .sample_en (b_en),
        .sample    (b_in)
    );

    // ==========================================================
    // compare and verdict
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    // ==========================================================
    // island A observers
    always @(posedge island_a_clock_in)
    begin
        if (mon_on && a_out !== a_prev)
        begin
            check(a_out, rows[a_n % 16].b_in);
            a_n++;
            a_prev = a_out;
        end
        if (mon_on && a_hold !== ah_prev)
        begin
            check(a_hold, b_hold);
            ah_prev = a_hold;
        end
    end

    // ==========================================================
    // island B observers
    always @(posedge island_b_clock_in)
    begin
        if (mon_on && b_out !== b_prev)
        begin
            check(b_out, rows[b_n % 16].a_in);
            b_n++;
            b_prev = b_out;
        end
        if (mon_on && q_valid === 1'b1)
        begin
            check(q_out, rows[q_k % 16].a_in);
            q_k++;
        end
        else if (q_valid === 1'b1)
        begin
            check(q_out, 8'h3c);
            q_x++;
        end
        if (mon_on && b_hold !== bh_prev)
        begin
            check(b_hold, bi_prev);
            bh_prev = b_hold;
        end
        // word the design samples at this edge
        bi_prev = b_in;
    end

    // ==========================================================
    // main sequence
    initial
    begin
        for (int i = 0; i < 16; i++)
        begin
            rows[i].a_in = 8'ha0 + 8'(i);
            rows[i].b_in = 8'h50 + 8'(i);
        end
        repeat (20) @(posedge island_b_clock_in);
        check(a_out | b_out | q_out | a_hold | b_hold, 8'h00);
        check({7'h0, q_valid}, 8'h00);
        @(posedge island_a_clock_in);
        rst_n <= 1'b1;
        repeat (4) @(posedge island_b_clock_in);
        mon_on  <= 1'b1;
        far_run <= 1'b1;
        @(posedge island_a_clock_in);
        // every other edge keeps the queue below full
        for (int i = 0; i < 56; i++)
        begin
            a_en <= 1'b1;
            a_in <= (i < 16) ? rows[i].a_in : 8'hee;
            @(posedge island_a_clock_in);
            a_en <= 1'b0;
            @(posedge island_a_clock_in);
        end
        far_gap <= 4'h3;
        repeat (40) @(posedge island_b_clock_in);
        far_run <= 1'b0;
        repeat (20) @(posedge island_a_clock_in);
        check(a_hold, b_hold);
        check(8'(q_k), 8'h10);
        check(8'(a_n >= 20), 8'h01);
        check(8'(b_n >= 20), 8'h01);
        mon_on = 1'b0;
        rst_n <= 1'b0;
        repeat (5) @(posedge island_b_clock_in);
        check(a_out | b_out | a_hold | b_hold, 8'h00);
        check({7'h0, q_valid}, 8'h00);
        // queue backs up with no pops, then drains
        @(posedge island_a_clock_in);
        rst_n <= 1'b1;
        repeat (4) @(posedge island_b_clock_in);
        @(posedge island_a_clock_in);
        far_gap <= 4'h0;
        a_en    <= 1'b1;
        a_in    <= 8'h3c;
        repeat (14) @(posedge island_a_clock_in);
        check({7'h0, q_valid}, 8'h00);
        far_run <= 1'b1;
        repeat (40) @(posedge island_b_clock_in);
        check(8'(q_x), 8'h10);
        results();
    end

    // ==========================================================
    // watchdog
    initial
    begin
        #20000;
        bad_count++;
        results();
    end
endmodule : dci_island_exchange_tb
